/* File: core/sdrmb_pkg.sv */
// shared constants for the two-bank synchronous dram and its controller
package sdrmb_pkg;
    localparam int unsigned CLK_PERIOD_PS    = 4000;
    localparam int unsigned POWER_HOLD_US    = 100;
    localparam int unsigned HOLD_CYCLES_DFLT = (POWER_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W            = 16;
    localparam logic [CNT_W-1:0] MLD_GAP     = 16'h0002;
    localparam logic [CNT_W-1:0] PRE_GAP     = 16'h0002;
    localparam logic [CNT_W-1:0] REF_GAP     = 16'h0008;

    localparam int unsigned ADDR_W    = 10;
    localparam int unsigned DATA_W    = 16;
    localparam int unsigned COL_W     = 8;
    localparam int unsigned MODE_W    = 10;
    localparam int unsigned MEM_DEPTH = 512;
    localparam int unsigned BANK_BIT  = 9;
    localparam int unsigned PRE_BIT   = 8;

    localparam int unsigned WM_LSB = 7;
    localparam int unsigned CL_LSB = 4;
    localparam int unsigned BT_BIT = 3;
    localparam int unsigned BL_LSB = 0;
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] CL_1    = 3'h1;
    localparam logic [2:0] CL_2    = 3'h2;
    localparam logic [2:0] CL_3    = 3'h3;
    localparam logic [2:0] WM_BURST  = 3'h0;
    localparam logic [2:0] WM_SINGLE = 3'h4;
    localparam logic [MODE_W-1:0] MODE_RST = 10'h023;

    // command code is {csN, rasN, casN, weN}
    localparam logic [3:0] CMD_MLD   = 4'h0;
    localparam logic [3:0] CMD_REF   = 4'h1;
    localparam logic [3:0] CMD_PRE   = 4'h2;
    localparam logic [3:0] CMD_ACT   = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ  = 4'h5;
    localparam logic [3:0] CMD_BST   = 4'h6;
    localparam logic [3:0] CMD_NOP   = 4'h7;

    localparam int unsigned REG_W    = 16;
    localparam logic [2:0] REG_MODE   = 3'h0;
    localparam logic [2:0] REG_CTRL   = 3'h1;
    localparam logic [2:0] REG_STATUS = 3'h2;
    localparam logic [2:0] REG_CMD    = 3'h3;
    localparam logic [2:0] REG_WDATA  = 3'h4;
    localparam logic [2:0] REG_RDATA  = 3'h5;
    localparam int unsigned CTRL_START_BIT  = 0;
    localparam int unsigned CTRL_MLDF_BIT   = 1;
    localparam int unsigned STAT_DONE_BIT   = 0;
    localparam int unsigned STAT_BUSY_BIT   = 1;
    localparam int unsigned STAT_REFUS_BIT  = 2;
    localparam int unsigned STAT_BADM_BIT   = 3;
    localparam int unsigned CMDREG_ADDR_LSB = 4;
endpackage : sdrmb_pkg

/* File: core/sdrmb_if.sv */
// pins between the memory controller and the dram
`timescale 1ns/1ps
`default_nettype none
interface sdrmb_if;
    import sdrmb_pkg::*;
    logic              clkGate;
    logic              csN;
    logic              rasN;
    logic              casN;
    logic              weN;
    logic [ADDR_W-1:0] addr;
    logic              lowByteMaskPin;
    logic              highByteMaskPin;
    logic [DATA_W-1:0] dqCtrl;
    logic              dqCtrlOe;
    logic [DATA_W-1:0] dqDev;
    logic              dqDevOe;

    modport ctrl (output clkGate, csN, rasN, casN, weN, addr, lowByteMaskPin, highByteMaskPin,
                  output dqCtrl, dqCtrlOe, input dqDev, dqDevOe);
    modport dev (input clkGate, csN, rasN, casN, weN, addr, lowByteMaskPin, highByteMaskPin,
                 input dqCtrl, dqCtrlOe, output dqDev, dqDevOe);
endinterface : sdrmb_if
`default_nettype wire

/* File: core/sdrmb_burst_col.sv */
// burst column address generator
`timescale 1ns/1ps
`default_nettype none
module sdrmb_burst_col
    import sdrmb_pkg::*;
(
    input  wire logic [COL_W-1:0] startCol,
    input  wire logic [COL_W-1:0] beat,
    input  wire logic [COL_W-1:0] wrapMask,
    input  wire logic             interleaved,
    output logic      [COL_W-1:0] col
);
    logic [COL_W-1:0] seqCol;
    logic [COL_W-1:0] ilvCol;

    assign seqCol = COL_W'(startCol + beat); // R12
    assign ilvCol = startCol ^ beat; // R13
    // high bits stay put, so the burst wraps inside its aligned block
    assign col = (startCol & ~wrapMask) | ((interleaved ? ilvCol : seqCol) & wrapMask); // R10
endmodule : sdrmb_burst_col
`default_nettype wire

/* File: core/sdrmb_device.sv */
// synchronous dram end: mode register, burst ordering and data storage
`timescale 1ns/1ps
`default_nettype none
module sdrmb_device
    import sdrmb_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    sdrmb_if.dev                   pins,
    output logic      [MODE_W-1:0] modeCfg,
    output logic                   burstActive
);
    typedef struct packed {
        logic [MODE_W-1:0]                   mode;
        logic                                act;
        logic                                wr;
        logic                                bank;
        logic [COL_W-1:0]                    start;
        logic [COL_W-1:0]                    cnt;
        logic [2:0]                          pv;
        logic [2:0][DATA_W-1:0]              pd;
        logic [MEM_DEPTH-1:0][DATA_W-1:0]    mem;
    } sdrmb_dev_st_t;

    sdrmb_dev_st_t s_r;
    sdrmb_dev_st_t s_nxt;

    logic [3:0]       cmd;
    logic             newRd;
    logic             newWr;
    logic             newCmd;
    logic             isBst;
    logic             isMld;
    logic             selBank;
    logic [COL_W-1:0] selStart;
    logic [COL_W-1:0] selCnt;
    logic [COL_W-1:0] lastBeat;
    logic [COL_W-1:0] col;
    logic [2:0]       blCode;
    logic [2:0]       clCode;
    logic [2:0]       wmCode;
    logic [8:0]       memIdx;

    assign cmd    = {pins.csN, pins.rasN, pins.casN, pins.weN};
    assign newRd  = cmd == CMD_READ;
    assign newWr  = cmd == CMD_WRITE;
    assign newCmd = newRd | newWr;
    assign isBst  = cmd == CMD_BST;
    assign isMld  = cmd == CMD_MLD;
    assign blCode = s_r.mode[BL_LSB +: 3];
    assign clCode = s_r.mode[CL_LSB +: 3];
    assign wmCode = s_r.mode[WM_LSB +: 3];

    // a new command restarts the burst from its own column at beat zero
    assign selBank  = newCmd ? pins.addr[BANK_BIT] : s_r.bank; // R11
    assign selStart = newCmd ? pins.addr[COL_W-1:0] : s_r.start; // R11
    assign selCnt   = newCmd ? '0 : s_r.cnt;
    assign memIdx   = {selBank, col};

    // last beat index doubles as the wrap mask
    always_comb
    begin
        case (blCode)
            BL_1:    lastBeat = 8'h00; // R09
            BL_2:    lastBeat = 8'h01; // R09
            BL_4:    lastBeat = 8'h03; // R09
            BL_8:    lastBeat = 8'h07; // R09
            BL_PAGE: lastBeat = 8'hFF; // R16
            default: lastBeat = 8'h00;
        endcase
    end

    sdrmb_burst_col u_col (
        .startCol    (selStart),
        .beat        (selCnt),
        .wrapMask    (lastBeat),
        .interleaved (s_r.mode[BT_BIT]),
        .col         (col)
    );

    always_comb
    begin
        logic moves;
        logic isWr;
        logic last;
        logic single;
        moves  = 1'b0;
        isWr   = 1'b0;
        last   = 1'b0;
        single = 1'b0;
        s_nxt  = s_r;
        // a suspended clock freezes every burst and the read pipe
        if (pins.clkGate)
        begin
            // burst stop ends the burst before this beat is done
            moves  = (newCmd | s_r.act) & ~isBst;
            isWr   = newCmd ? newWr : s_r.wr;
            single = isWr & (wmCode == WM_SINGLE); // R15
            // full page ends by itself only as a single write, otherwise only by a stop or a new command
            last   = single | ((blCode != BL_PAGE) & (selCnt == lastBeat)); // R16
            s_nxt.pv = {s_r.pv[1:0], moves & ~isWr};
            s_nxt.pd = {s_r.pd[1:0], s_r.mem[memIdx]}; // R11
            if (moves & isWr)
            begin
                // write latency is zero, so this beat takes the pins now
                if (!pins.lowByteMaskPin)
                begin
                    s_nxt.mem[memIdx][7:0] = pins.dqCtrl[7:0]; // R14
                end
                if (!pins.highByteMaskPin)
                begin
                    s_nxt.mem[memIdx][15:8] = pins.dqCtrl[15:8]; // R14
                end
            end
            s_nxt.act   = moves & ~last;
            s_nxt.wr    = isWr;
            s_nxt.bank  = selBank;
            s_nxt.start = selStart;
            s_nxt.cnt   = COL_W'(selCnt + 8'h01); // R16
            if (isMld)
            begin
                // accepted at any point of the start-up order
                s_nxt.mode = pins.addr[MODE_W-1:0]; // R04 R05
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // pipe stage n holds data fetched n+1 edges after its beat
    always_comb
    begin
        case (clCode)
            CL_1:
            begin
                pins.dqDevOe = s_r.pv[0]; // R08
                pins.dqDev   = s_r.pd[0];
            end
            CL_2:
            begin
                pins.dqDevOe = s_r.pv[1]; // R08
                pins.dqDev   = s_r.pd[1];
            end
            CL_3:
            begin
                pins.dqDevOe = s_r.pv[2]; // R08
                pins.dqDev   = s_r.pd[2];
            end
            default:
            begin
                // reserved latency: the device never drives the bus
                pins.dqDevOe = 1'b0;
                pins.dqDev   = '0;
            end
        endcase
    end

    assign modeCfg     = s_r.mode;
    assign burstActive = s_r.act;
endmodule : sdrmb_device
`default_nettype wire

/* File: core/sdrmb_ctrl.sv */
// memory controller end: power-on sequence and software command port
//
// Operation
// R01 - controller holds gate and masks high 100us
// R02 - controller then closes both banks
// R03 - two refreshes and mode load before access
// R04 - mode load accepted before or after refreshes
// R05 - mode load latches address 9..0 fields
// R06 - mode load only with both banks idle
// R07 - two cycles after mode load before next
// R08 - read data after programmed latency 1-3
// R09 - length code selects 1,2,4,8 or page
// R10 - order bit picks sequential or interleaved
// R11 - start column from command, rest internal
// R12 - sequential wraps within aligned block
// R13 - interleaved xors start with beat counter
// R14 - burst write starts at command cycle
// R15 - single write stores only commanded word
// R16 - full page wraps 256 until stopped
// R17 - controller never programs reserved codes; a mode written after start is loaded at start-up unchecked
`timescale 1ns/1ps
`default_nettype none
module sdrmb_ctrl
    import sdrmb_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DFLT
)
(
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [2:0]       regAddr,
    input  wire logic [REG_W-1:0] regWrData,
    input  wire logic             regWrEn,
    input  wire logic             regRdEn,
    output logic      [REG_W-1:0] regRdData,
    sdrmb_if.ctrl                 pins
);
    typedef enum logic [2:0] {ST_IDLE, ST_HOLD, ST_PRE, ST_REFA, ST_REFB, ST_MLD, ST_WAIT, ST_DONE} sdrmb_state_t;

    typedef struct packed {
        sdrmb_state_t      st;
        sdrmb_state_t      after;
        logic [CNT_W-1:0]  cnt;
        logic [MODE_W-1:0] mode;
        logic              mldFirst;
        logic              done;
        logic              refused;
        logic              waitRd;
        logic [3:0]        cmd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic              dqOe;
        logic              dqm;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic [REG_W-1:0]  rdOut;
    } sdrmb_ctrl_st_t;

    sdrmb_ctrl_st_t s_r;
    sdrmb_ctrl_st_t s_nxt;
    logic           modeOk;

    always_comb
    begin
        modeOk = (s_r.mode[CL_LSB +: 3] >= CL_1) && (s_r.mode[CL_LSB +: 3] <= CL_3); // R17
        if (s_r.mode[BL_LSB +: 3] == BL_PAGE)
        begin
            modeOk = modeOk && !s_r.mode[BT_BIT]; // R17
        end
        else if (s_r.mode[BL_LSB +: 3] > BL_8)
        begin
            modeOk = 1'b0;
        end
        if (s_r.mode[WM_LSB +: 3] != WM_BURST && s_r.mode[WM_LSB +: 3] != WM_SINGLE)
        begin
            modeOk = 1'b0;
        end
    end

    always_comb
    begin
        logic [3:0] uCmd;
        uCmd   = regWrData[3:0];
        s_nxt  = s_r;
        s_nxt.cmd  = CMD_NOP;
        s_nxt.dqOe = 1'b0;
        // masks stay high so burst beats past the first word are not stored
        s_nxt.dqm  = 1'b1;
        if (s_r.waitRd && pins.dqDevOe)
        begin
            s_nxt.rdata  = pins.dqDev;
            s_nxt.waitRd = 1'b0;
        end
        case (regAddr)
            REG_MODE:   s_nxt.rdOut = REG_W'(s_r.mode);
            REG_CTRL:   s_nxt.rdOut = REG_W'({s_r.mldFirst, 1'b0});
            REG_STATUS: s_nxt.rdOut = REG_W'({~modeOk, s_r.refused, s_r.st != ST_DONE && s_r.st != ST_IDLE, s_r.done});
            REG_WDATA:  s_nxt.rdOut = s_r.wdata;
            REG_RDATA:  s_nxt.rdOut = s_r.rdata;
            default:    s_nxt.rdOut = '0;
        endcase
        // the answer only moves on a read strobe
        if (!regRdEn)
        begin
            s_nxt.rdOut = s_r.rdOut;
        end
        if (regWrEn)
        begin
            case (regAddr)
                REG_MODE:  s_nxt.mode  = regWrData[MODE_W-1:0];
                REG_WDATA: s_nxt.wdata = regWrData;
                REG_STATUS:
                begin
                    if (regWrData[STAT_REFUS_BIT])
                    begin
                        s_nxt.refused = 1'b0;
                    end
                end
                REG_CTRL:
                begin
                    if (s_r.st == ST_IDLE)
                    begin
                        s_nxt.mldFirst = regWrData[CTRL_MLDF_BIT]; // R04
                    end
                    if (regWrData[CTRL_START_BIT])
                    begin
                        if (s_r.st == ST_IDLE && modeOk)
                        begin
                            s_nxt.st  = ST_HOLD;
                            s_nxt.cnt = CNT_W'(HOLD_CYCLES - 1); // R01
                        end
                        else
                        begin
                            s_nxt.refused = 1'b1;
                        end
                    end
                end
                REG_CMD:
                begin
                    // nothing reaches the pins before start-up is complete
                    if (s_r.st != ST_DONE || (uCmd == CMD_MLD && !modeOk)) // R03 R17
                    begin
                        s_nxt.refused = 1'b1;
                    end
                    else
                    begin
                        s_nxt.cmd  = uCmd;
                        s_nxt.addr = regWrData[CMDREG_ADDR_LSB +: ADDR_W];
                        if (uCmd == CMD_MLD)
                        begin
                            s_nxt.addr  = s_r.mode;
                            s_nxt.st    = ST_WAIT;
                            s_nxt.after = ST_DONE;
                            s_nxt.cnt   = MLD_GAP - 16'h0001; // R07
                        end
                        else if (uCmd == CMD_REF)
                        begin
                            s_nxt.st    = ST_WAIT;
                            s_nxt.after = ST_DONE;
                            s_nxt.cnt   = REF_GAP - 16'h0001;
                        end
                        if (uCmd == CMD_WRITE)
                        begin
                            s_nxt.dq   = s_r.wdata;
                            s_nxt.dqOe = 1'b1;
                            s_nxt.dqm  = 1'b0;
                        end
                        if (uCmd == CMD_READ)
                        begin
                            s_nxt.waitRd = 1'b1;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end
        case (s_r.st)
            ST_IDLE:
            begin
            end
            ST_HOLD:
            begin
                if (s_r.cnt == '0) // R01
                begin
                    s_nxt.st = ST_PRE;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            ST_PRE:
            begin
                s_nxt.cmd           = CMD_PRE;
                s_nxt.addr          = '0;
                s_nxt.addr[PRE_BIT] = 1'b1; // R02
                s_nxt.st            = ST_WAIT;
                s_nxt.after         = s_r.mldFirst ? ST_MLD : ST_REFA; // R04
                s_nxt.cnt           = PRE_GAP - 16'h0001;
            end
            ST_REFA, ST_REFB:
            begin
                s_nxt.cmd   = CMD_REF; // R03
                s_nxt.st    = ST_WAIT;
                s_nxt.cnt   = REF_GAP - 16'h0001;
                s_nxt.after = (s_r.st == ST_REFA) ? ST_REFB : (s_r.mldFirst ? ST_DONE : ST_MLD);
            end
            ST_MLD:
            begin
                s_nxt.cmd   = CMD_MLD; // R03 R06
                s_nxt.addr  = s_r.mode;
                s_nxt.st    = ST_WAIT;
                s_nxt.after = s_r.mldFirst ? ST_REFA : ST_DONE; // R04
                s_nxt.cnt   = MLD_GAP - 16'h0001; // R07
            end
            ST_WAIT:
            begin
                if (s_r.cnt <= 16'h0001) // R07
                begin
                    s_nxt.st = s_r.after;
                    if (s_r.after == ST_DONE)
                    begin
                        s_nxt.done = 1'b1;
                    end
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            ST_DONE:
            begin
            end
            default:
            begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r      <= '0;
            s_r.st   <= ST_IDLE;
            s_r.cmd  <= CMD_NOP;
            s_r.dqm  <= 1'b1;
            s_r.mode <= MODE_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // gate pin is held high from reset on
    assign pins.clkGate         = 1'b1; // R01
    assign {pins.csN, pins.rasN, pins.casN, pins.weN} = s_r.cmd;
    assign pins.addr            = s_r.addr;
    assign pins.lowByteMaskPin  = s_r.dqm; // R01
    assign pins.highByteMaskPin = s_r.dqm; // R01
    assign pins.dqCtrl          = s_r.dq;
    assign pins.dqCtrlOe        = s_r.dqOe;
    assign regRdData            = s_r.rdOut;
endmodule : sdrmb_ctrl
`default_nettype wire

/* File: sim/sdrmb_sva.sv */
// pin-level assertions between controller and dram
`timescale 1ns/1ps
`default_nettype none
module sdrmb_sva
    import sdrmb_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DFLT
)
(
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic              clkGate,
    input wire logic              csN,
    input wire logic              rasN,
    input wire logic              casN,
    input wire logic              weN,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              lowByteMaskPin,
    input wire logic              highByteMaskPin,
    input wire logic              dqCtrlOe,
    input wire logic              dqDevOe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic [3:0]        cmd;
    logic [CNT_W-1:0]  holdCnt_r;
    logic              started_r;
    logic [1:0]        refCnt_r;
    logic              mldSeen_r;
    logic [MODE_W-1:0] mode_r;
    logic [8:0]        runLen_r;
    assign cmd = {csN, rasN, casN, weN};
    // mode taken from the pins, not the device, so a latch fault there cannot hide itself
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            holdCnt_r <= '0;
            started_r <= 1'b0;
            refCnt_r  <= '0;
            mldSeen_r <= 1'b0;
            mode_r    <= '0;
            runLen_r  <= '0;
        end
        else
        begin
            holdCnt_r <= (holdCnt_r == '1) ? holdCnt_r : holdCnt_r + 1'b1;
            started_r <= started_r | (cmd != CMD_NOP);
            refCnt_r  <= (cmd == CMD_REF && refCnt_r != 2'h3) ? refCnt_r + 1'b1 : refCnt_r;
            mldSeen_r <= mldSeen_r | (cmd == CMD_MLD);
            mode_r    <= (cmd == CMD_MLD) ? addr : mode_r;
            runLen_r  <= dqDevOe ? runLen_r + 1'b1 : '0;
        end
    end
    AST_HOLD_MASKS: assert property (!started_r |-> clkGate && lowByteMaskPin && highByteMaskPin)
        else $error("gate or mask low before init");
    AST_HOLD_TIME: assert property (!started_r && cmd != CMD_NOP |-> holdCnt_r >= HOLD_CYCLES)
        else $error("first command before hold time");
    AST_FIRST_PRE: assert property (!started_r && cmd != CMD_NOP |-> cmd == CMD_PRE && addr[PRE_BIT])
        else $error("first command is not close all banks");
    AST_INIT_ORDER: assert property (cmd == CMD_READ || cmd == CMD_WRITE |-> refCnt_r >= 2'h2 && mldSeen_r)
        else $error("access before refreshes and mode load");
    AST_MLD_GAP: assert property (cmd == CMD_MLD |=> cmd == CMD_NOP)
        else $error("command too soon after mode load");
    AST_LAT1: assert property (cmd == CMD_READ && mode_r[6:4] == CL_1 |=> dqDevOe)
        else $error("latency 1 data late");
    AST_LAT2: assert property (cmd == CMD_READ && mode_r[6:4] == CL_2 |=> !dqDevOe ##1 dqDevOe)
        else $error("latency 2 data wrong cycle");
    AST_LAT3: assert property (cmd == CMD_READ && mode_r[6:4] == CL_3 |=> !dqDevOe [*2] ##1 dqDevOe)
        else $error("latency 3 data wrong cycle");
    AST_BURST_LEN: assert property ($fell(dqDevOe) && !mode_r[2] |-> runLen_r == (9'h001 << mode_r[1:0]))
        else $error("read burst length wrong");
    AST_WRITE_CYCLE: assert property (cmd == CMD_WRITE |-> dqCtrlOe && !lowByteMaskPin && !highByteMaskPin)
        else $error("write data not in command cycle");
endmodule : sdrmb_sva
`default_nettype wire

/* File: sim/sdrmb_bench.sv */
// bench: init orders, mode loads and burst orders across both ends
`timescale 1ns/1ps
`default_nettype none
module sdrmb_bench;
    import sdrmb_pkg::*;
    localparam int unsigned HOLD = 20;
    localparam logic [MODE_W-1:0] MODES [6] = '{10'h210, 10'h021, 10'h02A, 10'h033, 10'h03B, 10'h017};
    localparam logic [7:0] STARTS [6] = '{8'h03, 8'h01, 8'h01, 8'h02, 8'h05, 8'hFE};
    logic              clk;
    logic              arst_n;
    logic [2:0]        regAddr;
    logic [REG_W-1:0]  regWrData;
    logic              regWrEn;
    logic              regRdEn;
    logic [REG_W-1:0]  regRdData;
    logic [MODE_W-1:0] modeCfg;
    logic              burstAct;
    logic [REG_W-1:0]  rdv;
    int                miscompares;
    int                n_compared;
    sdrmb_if pins();
    sdrmb_ctrl #(.HOLD_CYCLES(HOLD)) i_sdrmb_ctrl (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .pins(pins));
    sdrmb_device i_sdrmb_device (.clk(clk), .arst_n(arst_n), .pins(pins), .modeCfg(modeCfg), .burstActive(burstAct));
    sdrmb_sva #(.HOLD_CYCLES(HOLD)) i_sdrmb_sva (.clk(clk), .arst_n(arst_n), .clkGate(pins.clkGate),
        .csN(pins.csN), .rasN(pins.rasN), .casN(pins.casN), .weN(pins.weN), .addr(pins.addr),
        .lowByteMaskPin(pins.lowByteMaskPin), .highByteMaskPin(pins.highByteMaskPin),
        .dqCtrlOe(pins.dqCtrlOe), .dqDevOe(pins.dqDevOe));
    task automatic report_and_stop();
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [REG_W-1:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge clk);
        regWrEn   <= 1'b0;
    endtask : wr
    // data is registered on the edge after the strobe and then held, so it is taken just past that edge
    task automatic rd(input logic [2:0] a, output logic [REG_W-1:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd
    task automatic wait_status(input int b, input logic v);
        logic [REG_W-1:0] s;
        for (int i = 0; i < 300; i++)
        begin
            rd(REG_STATUS, s);
            if (s[b] === v)
                return;
        end
        miscompares++;
        report_and_stop();
    endtask : wait_status
    task automatic issue(input logic [3:0] code, input logic [ADDR_W-1:0] a);
        wait_status(STAT_BUSY_BIT, 1'b0);
        wr(REG_CMD, {2'h0, a, code});
    endtask : issue
    task automatic load_mode(input logic [MODE_W-1:0] m);
        wr(REG_MODE, {6'h0, m});
        issue(CMD_MLD, '0);
        wait_status(STAT_BUSY_BIT, 1'b0);
        check({6'h0, modeCfg}, {6'h0, m});
    endtask : load_mode
    // data word at each written column (0-7, FE-FF) is 5A00 plus the column, so each beat names its column
    task automatic read_burst(input logic [7:0] col, input int len, input logic intl, input int n);
        logic [7:0] msk;
        logic [7:0] c;
        int         got;
        msk = 8'(len - 1);
        got = 0;
        issue(CMD_READ, {2'h0, col});
        for (int j = 0; j < 40 && got < n; j++)
        begin
            @(posedge clk);
            #1;
            if (pins.dqDevOe === 1'b1)
            begin
                c = intl ? (col ^ 8'(got)) : ((col & ~msk) | ((col + 8'(got)) & msk));
                check(pins.dqDev, 16'h5A00 | {8'h0, c});
                got++;
            end
        end
        check(16'(got), 16'(n));
    endtask : read_burst
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        arst_n      = 1'b0;
        regAddr     = '0;
        regWrData   = '0;
        regWrEn     = 1'b0;
        regRdEn     = 1'b0;
        miscompares = 0;
        n_compared  = 0;
        for (int k = 0; k < 2; k++)
        begin
            arst_n <= 1'b0;
            repeat (12) @(posedge clk);
            arst_n <= 1'b1;
            rd(REG_MODE, rdv);
            check(rdv, 16'h0023);
            wr(REG_CTRL, {14'h0, 1'(k), 1'b1});
            wait_status(STAT_DONE_BIT, 1'b1);
        end
        load_mode(MODES[0]);
        for (int i = 0; i < 10; i++)
        begin
            wr(REG_WDATA, 16'h5A00 | 16'((i < 8) ? i : i + 246));
            issue(CMD_WRITE, 10'((i < 8) ? i : i + 246));
        end
        for (int i = 0; i < 6; i++)
        begin
            load_mode(MODES[i]);
            read_burst(STARTS[i], (MODES[i][2:0] == BL_PAGE) ? 256 : 1 << MODES[i][1:0],
                MODES[i][BT_BIT], (MODES[i][2:0] == BL_PAGE) ? 4 : 1 << MODES[i][1:0]);
            rd(REG_RDATA, rdv);
            check(rdv, 16'h5A00 | {8'h0, STARTS[i]});
        end
        // a page burst has no end of its own until it is stopped
        check({15'h0, pins.dqDevOe}, 16'h0001);
        check({15'h0, burstAct}, 16'h0001);
        issue(CMD_BST, '0);
        repeat (4) @(posedge clk);
        #1;
        check({15'h0, pins.dqDevOe}, 16'h0000);
        check({15'h0, burstAct}, 16'h0000);
        wr(REG_MODE, 16'h0000);
        rd(REG_STATUS, rdv);
        check({15'h0, rdv[STAT_BADM_BIT]}, 16'h0001);
        issue(CMD_MLD, '0);
        rd(REG_STATUS, rdv);
        check({15'h0, rdv[STAT_REFUS_BIT]}, 16'h0001);
        wr(REG_STATUS, 16'h0004);
        rd(REG_STATUS, rdv);
        check({15'h0, rdv[STAT_REFUS_BIT]}, 16'h0000);
        check({6'h0, modeCfg}, 16'h0017);
        report_and_stop();
    end
endmodule : sdrmb_bench
`default_nettype wire
